// ===== idsr_params.svh
// Constants of the idle-state residency counter block: register offsets, field positions,
// reset values and idle depth codes.
// Assumes inclusion by bare name from any file that needs them; holds definitions only.
`ifndef IDSR_PARAMS_SVH
`define IDSR_PARAMS_SVH

// Register indices; the byte address of a low word is four times the index
`define IDSR_IDX_PKG_DEPTH3       12'h03F8
`define IDSR_IDX_PKG_DEPTH6       12'h03F9
`define IDSR_IDX_PKG_DEPTH7       12'h03FA
`define IDSR_IDX_CORE_DEPTH3      12'h03FC
`define IDSR_IDX_CORE_DEPTH6      12'h03FD
`define IDSR_IDX_CORE_DEPTH7      12'h03FE

// Upper halves of the counters sit at the low-word address plus this offset
`define IDSR_HI_HALF_OFFSET       14'h1000
// Core selection and live status words
`define IDSR_ADDR_CORE_SELECT     14'h2000
`define IDSR_ADDR_STATUS          14'h2004
`define IDSR_ADDR_WIDTH           14

// Field positions of the status word
`define IDSR_STAT_PKG_LSB         0
`define IDSR_STAT_CORE_LSB        4
`define IDSR_STAT_SEL_LSB         8

// Reset values
`define IDSR_COUNT_RESET          64'h0000_0000_0000_0000
`define IDSR_CORE_SELECT_RESET    1'h0

// Block geometry
`define IDSR_NUM_CORES            2
`define IDSR_NUM_DEPTHS           3
`define IDSR_NUM_COUNTERS         9
`define IDSR_DEPTH_CODE_WIDTH     3

// Processor-internal idle depth codes
`define IDSR_DEPTH_THREE          3'h3
`define IDSR_DEPTH_SIX            3'h6
`define IDSR_DEPTH_SEVEN          3'h7

`endif

// ===== idsr_pkg.sv
// Types shared by the idle-state residency counter block.
// Assumes idsr_params.svh for sizes; nothing is imported by users.
`include "idsr_params.svh"

package idsr_pkg;

	// One residency count, one time-stamp tick per unit
	typedef logic [63:0] idsr_count_type;

	// Processor-internal idle depth code
	typedef logic [`IDSR_DEPTH_CODE_WIDTH-1:0] idsr_depth_type;

	// Bus answer codes
	typedef enum logic [1:0]
	{
		IDSR_RESP_OKAY   = 2'h0,
		IDSR_RESP_SLVERR = 2'h2,
		IDSR_RESP_DECERR = 2'h3
	} idsr_resp_type;

endpackage : idsr_pkg

// ===== idsr_cnt_if.sv
// Carrier between the register front end and the counter bank.
// Assumes one clock domain; the front end drives tick and activity, the bank returns counts.
`timescale 1ns/100ps
`default_nettype none
`include "idsr_params.svh"

interface idsr_cnt_if;

	logic                                        tick;   // Time-stamp tick enable
	logic [`IDSR_NUM_COUNTERS-1:0]               active; // Idle condition per counter
	idsr_pkg::idsr_count_type                    value [`IDSR_NUM_COUNTERS]; // Counts

	modport bank
	(
		input  tick,
		input  active,
		output value
	);

	modport ctrl
	(
		output tick,
		output active,
		input  value
	);

endinterface : idsr_cnt_if

`default_nettype wire

// ===== idsr_counter_bank.sv
// Bank of free-running 64-bit residency counters.
// Assumes tick and activity come from logic on aclk; reset is synchronous, active low.
`timescale 1ns/100ps
`default_nettype none
`include "idsr_params.svh"

module idsr_counter_bank
(
	input  wire logic aclk,    // Block clock
	input  wire logic aresetn, // Synchronous reset, active low
	idsr_cnt_if.bank  cnt      // Tick, activity and counts
);

	genvar i;

	// One counter per idle condition; the value is a flop, so reads see a settled count
	generate
		for (i = 0; i < `IDSR_NUM_COUNTERS; i = i + 1)
		begin : g_count
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					cnt.value[i] <= `IDSR_COUNT_RESET;
				else if (cnt.tick && cnt.active[i])
					cnt.value[i] <= cnt.value[i] + 64'h0000_0000_0000_0001;
			end
		end
	endgenerate

endmodule : idsr_counter_bank

`default_nettype wire

// ===== idsr_top.sv
// Idle-state residency counters behind an AXI4-Lite slave.
// Assumes depth codes and the time-stamp tick come from logic on aclk, so no synchroniser.
// Contract
// - Package depth-three counter advances only while package is in depth three.
// - Package depth-six counter advances only while package is in depth six.
// - Package depth-seven counter advances only while package is in depth seven.
// - Each core has a depth-three counter advancing only in its own depth three.
// - Each core has a depth-six counter advancing only in its own depth six.
// - Each core has a depth-seven counter advancing only in its own depth seven.
// - Counters step once per time-stamp tick while their idle condition holds.
// - Reads return the full 64-bit count; software writes cannot change it.
// - Reset clears every counter so values count from the latest reset.
// - Per-core counters are read-only 64-bit registers, full width on reads.
// - Depths use the processor's internal state codes, not hint or OS numbering.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "idsr_params.svh"

module idsr_top
(
	input  wire logic                                        aclk,             // Clock, 25 MHz
	input  wire logic                                        aresetn,          // Sync reset, low
	input  wire logic                                        time_stamp_tick,  // Tick enable
	input  wire logic [`IDSR_DEPTH_CODE_WIDTH-1:0]           package_depth,    // Package depth
	input  wire logic [`IDSR_NUM_CORES*`IDSR_DEPTH_CODE_WIDTH-1:0] core_depth, // Per-core depths
	input  wire logic [`IDSR_ADDR_WIDTH-1:0]                 s_axi_awaddr,     // Write address
	input  wire logic [2:0]                                  s_axi_awprot,     // Unused
	input  wire logic                                        s_axi_awvalid,    // Address valid
	output var  logic                                        s_axi_awready,    // Address taken
	input  wire logic [31:0]                                 s_axi_wdata,      // Write data
	input  wire logic [3:0]                                  s_axi_wstrb,      // Byte enables
	input  wire logic                                        s_axi_wvalid,     // Data valid
	output var  logic                                        s_axi_wready,     // Data taken
	output var  logic [1:0]                                  s_axi_bresp,      // Write answer
	output var  logic                                        s_axi_bvalid,     // Answer valid
	input  wire logic                                        s_axi_bready,     // Answer taken
	input  wire logic [`IDSR_ADDR_WIDTH-1:0]                 s_axi_araddr,     // Read address
	input  wire logic [2:0]                                  s_axi_arprot,     // Unused
	input  wire logic                                        s_axi_arvalid,    // Address valid
	output var  logic                                        s_axi_arready,    // Address taken
	output var  logic [31:0]                                 s_axi_rdata,      // Read data
	output var  logic [1:0]                                  s_axi_rresp,      // Read answer
	output var  logic                                        s_axi_rvalid,     // Data valid
	input  wire logic                                        s_axi_rready      // Data taken
);

	localparam int NREG = 6;

	// Word addresses of the low halves, in counter-register order
	localparam logic [`IDSR_ADDR_WIDTH-1:0] LO_ADDR [NREG] = '{
		{`IDSR_IDX_PKG_DEPTH3, 2'h0},
		{`IDSR_IDX_PKG_DEPTH6, 2'h0},
		{`IDSR_IDX_PKG_DEPTH7, 2'h0},
		{`IDSR_IDX_CORE_DEPTH3, 2'h0},
		{`IDSR_IDX_CORE_DEPTH6, 2'h0},
		{`IDSR_IDX_CORE_DEPTH7, 2'h0}
	};

	idsr_cnt_if cnt ();

	// Counter bank
	idsr_counter_bank u_bank
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.cnt     (cnt)
	);

	// Idle conditions and core selection
	logic                                  core_select_r;
	logic [`IDSR_NUM_COUNTERS-1:0]         active;
	idsr_pkg::idsr_depth_type              sel_core_depth;

	// Write path state
	logic                                  aw_held_r;
	logic                                  w_held_r;
	logic [`IDSR_ADDR_WIDTH-1:0]           waddr_r;
	logic [31:0]                           wdata_r;
	logic [3:0]                            wstrb_r;
	idsr_pkg::idsr_resp_type               wresp_nxt;

	// Read path state
	logic [31:0]                           rdata_nxt;
	idsr_pkg::idsr_resp_type               rresp_nxt;
	logic [31:0]                           snap_hi_r [NREG];
	logic [NREG-1:0]                       lo_hit;
	logic [NREG-1:0]                       hi_hit;
	idsr_pkg::idsr_count_type              reg_value [NREG];
	logic [31:0]                           status_word;

	// Handshake events and decoded targets
	logic                                  ar_take;
	logic                                  aw_take;
	logic                                  w_take;
	logic                                  wr_commit;
	logic [NREG-1:0]                       wr_cnt_hit;
	logic                                  sel_rd_hit;
	logic                                  stat_rd_hit;
	logic                                  sel_wr_hit;
	logic                                  stat_wr_hit;

	genvar c;

	// Package counters compare the raw internal depth code; no hint translation is done
	assign active[0] = (package_depth == `IDSR_DEPTH_THREE);
	assign active[1] = (package_depth == `IDSR_DEPTH_SIX);
	assign active[2] = (package_depth == `IDSR_DEPTH_SEVEN);

	// Each core owns three counters, indexed from three upward
	generate
		for (c = 0; c < `IDSR_NUM_CORES; c = c + 1)
		begin : g_core
			assign active[3+3*c] = (core_depth[3*c +: 3] == `IDSR_DEPTH_THREE);
			assign active[4+3*c] = (core_depth[3*c +: 3] == `IDSR_DEPTH_SIX);
			assign active[5+3*c] = (core_depth[3*c +: 3] == `IDSR_DEPTH_SEVEN);
		end
	endgenerate

	// Tick drives every counter directly, so one count is one tick
	assign cnt.tick   = time_stamp_tick;
	assign cnt.active = active;

	// One name per address and write-data handshake, so every process on those channels tests the same condition
	assign ar_take   = s_axi_arvalid && s_axi_arready;
	assign aw_take   = s_axi_awvalid && s_axi_awready;
	assign w_take    = s_axi_wvalid && s_axi_wready;
	// A write commits once both halves are held and the previous answer has gone
	assign wr_commit = aw_held_r && w_held_r && !s_axi_bvalid;

	// Control words decoded once for the read and the write side
	assign sel_rd_hit  = (s_axi_araddr == `IDSR_ADDR_CORE_SELECT);
	assign stat_rd_hit = (s_axi_araddr == `IDSR_ADDR_STATUS);
	assign sel_wr_hit  = (waddr_r == `IDSR_ADDR_CORE_SELECT);
	assign stat_wr_hit = (waddr_r == `IDSR_ADDR_STATUS);

	// Register view: package counters fixed, core counters through the selected core
	always_comb
	begin
		reg_value[0] = cnt.value[0];
		reg_value[1] = cnt.value[1];
		reg_value[2] = cnt.value[2];
		if (core_select_r)
		begin
			reg_value[3] = cnt.value[6];
			reg_value[4] = cnt.value[7];
			reg_value[5] = cnt.value[8];
		end
		else
		begin
			reg_value[3] = cnt.value[3];
			reg_value[4] = cnt.value[4];
			reg_value[5] = cnt.value[5];
		end
	end

	// Depth of the selected core, shown in the status word
	assign sel_core_depth = core_select_r ? core_depth[5:3] : core_depth[2:0];

	// Address hits of the counter words; the write side looks at the held address
	generate
		for (c = 0; c < NREG; c = c + 1)
		begin : g_hit
			assign lo_hit[c] = (s_axi_araddr == LO_ADDR[c]);
			assign hi_hit[c] = (s_axi_araddr == LO_ADDR[c] + `IDSR_HI_HALF_OFFSET);
			assign wr_cnt_hit[c] = (waddr_r == LO_ADDR[c]) || (waddr_r == LO_ADDR[c] + `IDSR_HI_HALF_OFFSET);
		end
	endgenerate

	// Upper halves are caught when the low half is read, so a low-then-high pair is coherent
	generate
		for (c = 0; c < NREG; c = c + 1)
		begin : g_snap
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					snap_hi_r[c] <= 32'h0000_0000;
				else if (ar_take && lo_hit[c])
					snap_hi_r[c] <= reg_value[c][63:32];
			end
		end
	endgenerate

	// Live status word; raw depth codes, so software sees the internal numbering
	always_comb
	begin
		status_word                           = 32'h0000_0000;
		status_word[`IDSR_STAT_PKG_LSB +: 3]  = package_depth;
		status_word[`IDSR_STAT_CORE_LSB +: 3] = sel_core_depth;
		status_word[`IDSR_STAT_SEL_LSB]       = core_select_r;
	end

	// Read decode; a high half read alone returns the last snapshot, zero after reset
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		rresp_nxt = idsr_pkg::IDSR_RESP_DECERR;
		for (int k = 0; k < NREG; k = k + 1)
		begin
			if (lo_hit[k])
			begin
				rdata_nxt = reg_value[k][31:0];
				rresp_nxt = idsr_pkg::IDSR_RESP_OKAY;
			end
			if (hi_hit[k])
			begin
				rdata_nxt = snap_hi_r[k];
				rresp_nxt = idsr_pkg::IDSR_RESP_OKAY;
			end
		end
		if (sel_rd_hit)
		begin
			rdata_nxt = {31'h0000_0000, core_select_r};
			rresp_nxt = idsr_pkg::IDSR_RESP_OKAY;
		end
		if (stat_rd_hit)
		begin
			rdata_nxt = status_word;
			rresp_nxt = idsr_pkg::IDSR_RESP_OKAY;
		end
	end

	// Read address channel: one read outstanding, ready drops while the answer waits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else if (ar_take)
			s_axi_arready <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// Read answer valid: set right after the address is taken, held until the master takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_rvalid <= 1'b0;
		else if (ar_take)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Read payload: captured only on the taking edge, so it stands unchanged while rvalid waits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (ar_take)
		begin
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
		end
	end

	// Write address capture; either channel may arrive first
	// Ready stays low while an answer is pending, so at most one write is in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r     <= 1'b0;
			waddr_r       <= '0;
			s_axi_awready <= 1'b0;
		end
		else if (aw_take)
		begin
			aw_held_r     <= 1'b1;
			waddr_r       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (wr_commit)
			aw_held_r <= 1'b0;
		else if (!aw_held_r && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	// Write data capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r     <= 1'b0;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (w_take)
		begin
			w_held_r     <= 1'b1;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else if (wr_commit)
			w_held_r <= 1'b0;
		else if (!w_held_r && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	// Write decode: counters refuse writes with a slave error, so software cannot alter them
	always_comb
	begin
		wresp_nxt = idsr_pkg::IDSR_RESP_DECERR;
		if (|wr_cnt_hit)
			wresp_nxt = idsr_pkg::IDSR_RESP_SLVERR;
		if (sel_wr_hit)
			wresp_nxt = idsr_pkg::IDSR_RESP_OKAY;
		if (stat_wr_hit)
			wresp_nxt = idsr_pkg::IDSR_RESP_SLVERR;
	end

	// Core selection steers which core's counters the per-core registers show
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			core_select_r <= `IDSR_CORE_SELECT_RESET;
		else if (wr_commit && sel_wr_hit && wstrb_r[0])
			core_select_r <= wdata_r[0];
	end

	// Write answer valid once both halves are in; held until the master takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bvalid <= 1'b0;
		else if (wr_commit)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Write answer code, fixed at the commit edge so it cannot change while bvalid stands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bresp <= 2'h0;
		else if (wr_commit)
			s_axi_bresp <= wresp_nxt;
	end

endmodule : idsr_top

`default_nettype wire

// ===== idsr_top_props.sv
// Bus-side checks for the residency counter block.
// Assumes it is bound to idsr_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module idsr_props
(
	input wire logic        aclk,          // Clock
	input wire logic        aresetn,       // Reset, low
	input wire logic [13:0] s_axi_awaddr,  // Write address
	input wire logic        s_axi_awvalid, // Address valid
	input wire logic        s_axi_awready, // Address taken
	input wire logic        s_axi_wvalid,  // Data valid
	input wire logic        s_axi_wready,  // Data taken
	input wire logic [1:0]  s_axi_bresp,   // Write answer
	input wire logic        s_axi_bvalid,  // Answer valid
	input wire logic        s_axi_bready,  // Answer taken
	input wire logic [13:0] s_axi_araddr,  // Read address
	input wire logic        s_axi_arvalid, // Address valid
	input wire logic        s_axi_arready, // Address taken
	input wire logic [31:0] s_axi_rdata,   // Read data
	input wire logic [1:0]  s_axi_rresp,   // Read answer
	input wire logic        s_axi_rvalid,  // Data valid
	input wire logic        s_axi_rready   // Data taken
);
	logic wr_cnt_r;
	logic rd_cnt_r;

	// Counter words, low or high half; the gap at 0xFEC is unmapped
	function automatic logic is_cnt(logic [13:0] a);
		return !a[13] && a[11:0] >= 12'hFE0 && a[11:0] <= 12'hFF8 && a[11:0] != 12'hFEC && a[1:0] == 2'h0;
	endfunction : is_cnt

	// Remember whether the request in flight aims at a counter
	always_ff @(posedge aclk)
		wr_cnt_r <= !aresetn ? 1'b0 : (s_axi_awvalid && s_axi_awready) ? is_cnt(s_axi_awaddr) : wr_cnt_r;
	always_ff @(posedge aclk)
		rd_cnt_r <= !aresetn ? 1'b0 : (s_axi_arvalid && s_axi_arready) ? is_cnt(s_axi_araddr) : rd_cnt_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ro_write; s_axi_bvalid && wr_cnt_r |-> s_axi_bresp == 2'h2; endproperty
	a_ro_write: assert property (p_ro_write) else $error("counter write not refused");
	property p_rd_cnt; s_axi_rvalid && rd_cnt_r |-> s_axi_rresp == 2'h0; endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("counter read not okay");
	property p_rst_quiet; $rose(aresetn) |-> !s_axi_arready && !s_axi_rvalid && !s_axi_bvalid ##1 s_axi_arready;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("bus not quiet after reset");
	property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer timing");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer not held");
	property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]; endproperty
	a_aw_drop: assert property (p_aw_drop) else $error("write address ready early");
endmodule : idsr_props

bind idsr_top idsr_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== tb_idsr.sv
// Self-checking bench for the residency counter block.
// Assumes idsr_top with its bound checker; the bench is the only bus master.
`timescale 1ns/100ps
`default_nettype none
`include "idsr_params.svh"
module tb;
	logic        aclk, aresetn, time_stamp_tick, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [2:0]  package_depth;
	logic [5:0]  core_depth;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [63:0] exp_r [9];
	int          errors, n_compared;

	idsr_top dut (.aclk, .aresetn, .time_stamp_tick, .package_depth, .core_depth, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	function automatic logic [2:0] code(int j);
		return j == 0 ? `IDSR_DEPTH_THREE : j == 1 ? `IDSR_DEPTH_SIX : `IDSR_DEPTH_SEVEN;
	endfunction : code

	// Reference counts from the inputs the bench drives; one step per tick edge
	always @(posedge aclk)
		for (int j = 0; j < 3; j++)
		begin
			exp_r[j] <= !aresetn ? 64'h0 : exp_r[j] + 64'(time_stamp_tick && package_depth == code(j));
			for (int c = 0; c < 2; c++)
				exp_r[3 + 3 * c + j] <= !aresetn ? 64'h0 :
					exp_r[3 + 3 * c + j] + 64'(time_stamp_tick && core_depth[3 * c +: 3] == code(j));
		end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task automatic chk(string what, logic [63:0] seen, logic [63:0] want);
		n_compared++;
		if (seen !== want)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic hang();
		errors++;
		wrap_up();
	endtask : hang

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 64)
			hang();
	endtask : wr

	task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 64)
			hang();
	endtask : rd

	// Low word first, so the high half comes from the same snapshot
	task automatic rd64(input logic [11:0] idx, output logic [63:0] v);
		logic [1:0] r;
		rd({idx, 2'h0}, v[31:0], r);
		chk("low resp", 64'(r), 64'h0);
		rd({idx, 2'h0} + `IDSR_HI_HALF_OFFSET, v[63:32], r);
		chk("high resp", 64'(r), 64'h0);
	endtask : rd64

	task automatic chk_all();
		logic [1:0]  r;
		logic [63:0] v;
		for (int c = 0; c < 2; c++)
		begin
			wr(`IDSR_ADDR_CORE_SELECT, 32'(c), r);
			chk("select resp", 64'(r), 64'h0);
			for (int j = 0; j < 3; j++)
			begin
				rd64(12'(`IDSR_IDX_PKG_DEPTH3 + j), v);
				chk("package count", v, exp_r[j]);
				rd64(12'(`IDSR_IDX_CORE_DEPTH3 + j), v);
				chk("core count", v, exp_r[3 + 3 * c + j]);
			end
		end
	endtask : chk_all

	// Every code on both scopes, tick toggling so idle cycles without a tick are seen too
	task automatic s_depths();
		for (int d = 0; d < 8; d++)
		begin
			@(posedge aclk);
			package_depth <= 3'(d);
			core_depth <= {3'(d) ^ 3'h1, 3'(d)};
			for (int k = 0; k < 2 * d + 2; k++)
			begin
				@(posedge aclk);
				time_stamp_tick <= k[0];
			end
			@(posedge aclk);
			time_stamp_tick <= 1'b0;
			chk_all();
		end
	endtask : s_depths

	task automatic s_readonly();
		logic [1:0]  r;
		logic [31:0] d;
		logic [63:0] w;
		wr(14'h0FE0, 32'hFFFF_FFFF, r);
		chk("low write resp", 64'(r), 64'h2);
		wr(14'h1FF8, 32'hFFFF_FFFF, r);
		chk("high write resp", 64'(r), 64'h2);
		rd(14'h0100, d, r);
		chk("unmapped resp", 64'(r), 64'h3);
		chk("unmapped data", 64'(d), 64'h0);
		chk_all();
		// chk_all leaves core one selected; depths stay as the last depth scenario left them
		rd(`IDSR_ADDR_CORE_SELECT, d, r);
		chk("select word", 64'(d), 64'h1);
		chk("select read resp", 64'(r), 64'h0);
		rd(`IDSR_ADDR_STATUS, d, r);
		w = 64'(package_depth) << `IDSR_STAT_PKG_LSB | 64'(core_depth[5:3]) << `IDSR_STAT_CORE_LSB;
		chk("status word", 64'(d), w | 64'h1 << `IDSR_STAT_SEL_LSB);
		chk("status read resp", 64'(r), 64'h0);
		wr(`IDSR_ADDR_STATUS, 32'h0000_0000, r);
		chk("status write resp", 64'(r), 64'h2);
	endtask : s_readonly

	// Reset in mid-count must bring every counter back to zero
	task automatic s_rerst();
		@(posedge aclk);
		package_depth <= 3'h7;
		time_stamp_tick <= 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		time_stamp_tick <= 1'b0;
		chk_all();
	endtask : s_rerst

	initial
	begin
		aresetn = 1'b0;
		time_stamp_tick = 1'b0;
		package_depth = 3'h0;
		core_depth = 6'h00;
		s_axi_awaddr = 14'h0000;
		s_axi_araddr = 14'h0000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk_all();
		s_depths();
		s_readonly();
		s_rerst();
		wrap_up();
	end
endmodule : tb
`default_nettype wire
